// file: verilog/mpg_defs.svh
// Register indices, field positions, reset values of the GPIO block
`ifndef MPG_DEFS_SVH
`define MPG_DEFS_SVH
// --------------------------------------------------
// Register indices, byte address is four times these
// --------------------------------------------------
`define MPG_IDX_DIR0 16'hff20
`define MPG_IDX_DIR1 16'hff21
`define MPG_IDX_DIR3 16'hff23
`define MPG_IDX_DIR6 16'hff26
`define MPG_IDX_DIR12 16'hff2c
`define MPG_IDX_DATA0 16'hff00
`define MPG_IDX_DATA1 16'hff01
`define MPG_IDX_DATA3 16'hff03
`define MPG_IDX_DATA6 16'hff06
`define MPG_IDX_DATA12 16'hff0c
`define MPG_IDX_PU0 16'hff30
`define MPG_IDX_PU1 16'hff31
`define MPG_IDX_PU3 16'hff33
`define MPG_IDX_PULLUP_REG_PORT_TWELVE 16'hff3c
// --------------------------------------------------
// Pin vector fields
// --------------------------------------------------
`define MPG_P0_LSB 0
`define MPG_P0_W 2
`define MPG_P1_LSB 2
`define MPG_P1_W 8
`define MPG_P3_LSB 10
`define MPG_P3_W 4
`define MPG_P6_LSB 14
`define MPG_P6_W 2
`define MPG_P12_LSB 16
`define MPG_P12_W 3
`define MPG_OD_MASK 19'h0c000
`define MPG_PU_MASK 19'h13fff
// --------------------------------------------------
// Reset values
// --------------------------------------------------
`define MPG_DIR_RST 19'h7ffff
`define MPG_LATCH_RST 19'h00000
`define MPG_PU_RST 19'h00000
`endif

// file: verilog/mpg_pkg.sv
// Types shared by the GPIO block modules
`default_nettype none
package mpg_pkg;
   typedef logic [18:0] mpg_pins_t;
   typedef enum logic [1:0] {KIND_NONE, KIND_DIR, KIND_DATA, KIND_PU} mpg_kind_t;
   typedef enum logic [2:0] {PORT0, PORT1, PORT3, PORT6, PORT12} mpg_port_t;
   typedef struct packed
   {
      mpg_kind_t kind;
      mpg_port_t port;
   } mpg_dec_t;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_WR = 3'b010,
      ST_RWAIT = 3'b100
   } mpg_ahb_st_t;
endpackage
`default_nettype wire

// file: verilog/mpg_reg_if.sv
// Register access channel between bus slave and register file
`default_nettype none
interface mpg_reg_if;
   logic wr;
   logic [15:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport slave (output wr, output idx, output wdata, input rdata);
   modport regs (input wr, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// file: verilog/mpg_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module mpg_pin_sync (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Pins in, settled levels out
   input wire mpg_pkg::mpg_pins_t i_d,
   output mpg_pkg::mpg_pins_t o_q
);
   import mpg_pkg::*;
   mpg_pins_t s1, s2, s3, agree;
   // Stage one feeds stage two only
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end
      else
      begin
         s1 <= i_d;
         s2 <= s1;
         s3 <= s2;
      end
   end
   assign agree = s2 ~^ s3;
   // Per bit: a change counts once stages two and three agree
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_q <= '0;
      else
         o_q <= (agree & s3) | (~agree & o_q);
   end
endmodule // mpg_pin_sync
`default_nettype wire

// file: verilog/mpg_ahb_slave.sv
// AHB-Lite slave front end for the GPIO registers
`default_nettype none
module mpg_ahb_slave (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // AHB-Lite
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic [31:0] o_hrdata,
   output logic o_hresp,
   // Register channel
   mpg_reg_if.slave rif
);
   import mpg_pkg::*;
   mpg_ahb_st_t state;
   logic accept;
   assign accept = i_hsel & i_htrans[1] & i_hready;
   // ------------------------------------------
   // Phase tracking
   // ------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         state <= ST_IDLE;
      else
         unique case (state)
            ST_IDLE, ST_WR:
               if (accept)
                  state <= i_hwrite ? ST_WR : ST_RWAIT;
               else
                  state <= ST_IDLE;
            ST_RWAIT:
               state <= ST_IDLE;
         endcase
   end
   // Addresses above the map decode to index zero, which is unmapped
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         rif.idx <= 16'h0000;
      else if (accept)
         rif.idx <= (i_haddr[31:18] == 14'h0000) ? i_haddr[17:2] : 16'h0000;
   end
   // One wait state on reads so the data comes from a flop
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_hrdata <= 32'h0000_0000;
      else if (state == ST_RWAIT)
         o_hrdata <= {24'h00_0000, rif.rdata};
   end
   assign o_hreadyout = (state != ST_RWAIT);
   assign o_hresp = 1'b0;
   assign rif.wr = (state == ST_WR);
   assign rif.wdata = i_hwdata[7:0];
endmodule // mpg_ahb_slave
`default_nettype wire

// file: verilog/mpg_gpio_top.sv
// Multi-port GPIO block: registers, pin drive and pin readback
//
// Implementation choices: the address map and the AHB-Lite register port.
`include "mpg_defs.svh"
`default_nettype none
// --------------------------------------------------
// Operation
// - Port zero: two pins with output latch
// - Direction chosen per bit by direction register
// - Pull-up acts only in input mode
// - Reset puts port zero into input
// - Nineteen pins: seventeen push-pull, two open-drain
// - Port six open-drain: zero pulls low
// - Port twelve pull-up on bit zero only
// - Pull-up registers for ports 0,1,3,12 only
// - One data register per port, latch write
// - Pins shared with alternate on-chip functions
// - Port one: eight pins, full control
// - Port three: four pins, full control
// - Port twelve: three pins, latch and direction
// --------------------------------------------------
module mpg_gpio_top (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic [31:0] o_hrdata,
   output logic o_hresp,
   // Pads
   input wire mpg_pkg::mpg_pins_t i_pin_in,
   output mpg_pkg::mpg_pins_t o_pin_out,
   output mpg_pkg::mpg_pins_t o_pin_oe,
   output mpg_pkg::mpg_pins_t o_pullup_en,
   // Alternate functions
   input wire mpg_pkg::mpg_pins_t i_alt_en,
   input wire mpg_pkg::mpg_pins_t i_alt_out,
   output mpg_pkg::mpg_pins_t o_alt_in
);
   import mpg_pkg::*;

   mpg_pins_t dir;
   mpg_pins_t latch;
   mpg_pins_t pu;
   mpg_pins_t pin_sync;
   mpg_pins_t view;
   mpg_pins_t value;
   mpg_dec_t dec;
   logic any_dir_wr;

   mpg_reg_if rif ();

   // --------------------------------------------------
   // Field helpers
   // --------------------------------------------------
   function automatic logic [7:0] fld(input mpg_pins_t v, input mpg_port_t p);
      logic [7:0] r;
      r = 8'h00;
      unique case (p)
         PORT0: r[`MPG_P0_W-1:0] = v[`MPG_P0_LSB +: `MPG_P0_W];
         PORT1: r[`MPG_P1_W-1:0] = v[`MPG_P1_LSB +: `MPG_P1_W];
         PORT3: r[`MPG_P3_W-1:0] = v[`MPG_P3_LSB +: `MPG_P3_W];
         PORT6: r[`MPG_P6_W-1:0] = v[`MPG_P6_LSB +: `MPG_P6_W];
         PORT12: r[`MPG_P12_W-1:0] = v[`MPG_P12_LSB +: `MPG_P12_W];
      endcase
      return r;
   endfunction

   function automatic mpg_pins_t put(input mpg_pins_t v, input mpg_port_t p, input logic [7:0] d);
      mpg_pins_t r;
      r = v;
      unique case (p)
         PORT0: r[`MPG_P0_LSB +: `MPG_P0_W] = d[`MPG_P0_W-1:0];
         PORT1: r[`MPG_P1_LSB +: `MPG_P1_W] = d[`MPG_P1_W-1:0];
         PORT3: r[`MPG_P3_LSB +: `MPG_P3_W] = d[`MPG_P3_W-1:0];
         PORT6: r[`MPG_P6_LSB +: `MPG_P6_W] = d[`MPG_P6_W-1:0];
         PORT12: r[`MPG_P12_LSB +: `MPG_P12_W] = d[`MPG_P12_W-1:0];
      endcase
      return r;
   endfunction

   function automatic mpg_dec_t mk(input mpg_kind_t k, input mpg_port_t p);
      mpg_dec_t d;
      d.kind = k;
      d.port = p;
      return d;
   endfunction

   // Port six has no pull-up register, so its index is absent
   function automatic mpg_dec_t decode(input logic [15:0] idx);
      mpg_dec_t d;
      d = mk(KIND_NONE, PORT0);
      case (idx)
         `MPG_IDX_DIR0: d = mk(KIND_DIR, PORT0);
         `MPG_IDX_DIR1: d = mk(KIND_DIR, PORT1);
         `MPG_IDX_DIR3: d = mk(KIND_DIR, PORT3);
         `MPG_IDX_DIR6: d = mk(KIND_DIR, PORT6);
         `MPG_IDX_DIR12: d = mk(KIND_DIR, PORT12);
         `MPG_IDX_DATA0: d = mk(KIND_DATA, PORT0);
         `MPG_IDX_DATA1: d = mk(KIND_DATA, PORT1);
         `MPG_IDX_DATA3: d = mk(KIND_DATA, PORT3);
         `MPG_IDX_DATA6: d = mk(KIND_DATA, PORT6);
         `MPG_IDX_DATA12: d = mk(KIND_DATA, PORT12);
         `MPG_IDX_PU0: d = mk(KIND_PU, PORT0);
         `MPG_IDX_PU1: d = mk(KIND_PU, PORT1);
         `MPG_IDX_PU3: d = mk(KIND_PU, PORT3);
         `MPG_IDX_PULLUP_REG_PORT_TWELVE: d = mk(KIND_PU, PORT12);
         default: d = mk(KIND_NONE, PORT0);
      endcase
      return d;
   endfunction

   // --------------------------------------------------
   // Bus front end and pin synchroniser
   // --------------------------------------------------
   mpg_ahb_slave u_slave (
      .i_clk (i_clk),
      .i_resetn (i_resetn),
      .i_hsel (i_hsel),
      .i_haddr (i_haddr),
      .i_htrans (i_htrans),
      .i_hwrite (i_hwrite),
      .i_hwdata (i_hwdata),
      .i_hready (i_hready),
      .o_hreadyout (o_hreadyout),
      .o_hrdata (o_hrdata),
      .o_hresp (o_hresp),
      .rif (rif.slave)
   );

   // Synchronised levels also feed alternate-function inputs
   mpg_pin_sync u_sync (
      .i_clk (i_clk),
      .i_resetn (i_resetn),
      .i_d (i_pin_in),
      .o_q (pin_sync)
   );
   assign o_alt_in = pin_sync;

   assign dec = decode(rif.idx);

   // --------------------------------------------------
   // Register file
   // --------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         dir <= `MPG_DIR_RST;
      else if (rif.wr && dec.kind == KIND_DIR)
         dir <= put(dir, dec.port, rif.wdata);
   end

   // Latch is written even in input mode, ready for the switch
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         latch <= `MPG_LATCH_RST;
      else if (rif.wr && dec.kind == KIND_DATA)
         latch <= put(latch, dec.port, rif.wdata);
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         pu <= `MPG_PU_RST;
      else if (rif.wr && dec.kind == KIND_PU)
         pu <= put(pu, dec.port, rif.wdata) & `MPG_PU_MASK;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         any_dir_wr <= 1'b0;
      else if (rif.wr && dec.kind == KIND_DIR)
         any_dir_wr <= 1'b1;
   end

   // Read view: settled pin for inputs, latch for outputs
   assign view = (dir & pin_sync) | (~dir & latch);

   // Unused direction bits read as one
   always_comb
   begin
      unique case (dec.kind)
         KIND_DIR: rif.rdata = fld(dir, dec.port) | ~fld(mpg_pins_t'('1), dec.port);
         KIND_DATA: rif.rdata = fld(view, dec.port);
         KIND_PU: rif.rdata = fld(pu, dec.port);
         KIND_NONE: rif.rdata = 8'h00;
      endcase
   end

   // --------------------------------------------------
   // Pin drive
   // --------------------------------------------------
   // Alternate output replaces the latch; direction still rules
   assign value = (i_alt_en & i_alt_out) | (~i_alt_en & latch);

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_pin_out <= '0;
         o_pin_oe <= '0;
      end
      else
      begin
         o_pin_out <= value & ~`MPG_OD_MASK;
         o_pin_oe <= ~dir & (~`MPG_OD_MASK | ~value);
      end
   end

   // Pull-up disconnected whenever the pin drives
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_pullup_en <= '0;
      else
         o_pullup_en <= pu & dir;
   end

   // --------------------------------------------------
   // Checks
   // --------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   reset_input_a: assert property (
      !any_dir_wr |-> (dir == `MPG_DIR_RST && o_pin_oe == '0))
      else $error("pins left input mode without a direction write");

   dir_write_a: assert property (
      (rif.wr && dec.kind == KIND_DIR)
      |=> fld(dir, $past(dec.port)) == (($past(rif.wdata)) & fld(mpg_pins_t'('1), $past(dec.port))))
      else $error("direction write not stored");

   latch_write_a: assert property (
      (rif.wr && dec.kind == KIND_DATA && dec.port == PORT0)
      |=> latch[1:0] == $past(rif.wdata[1:0]))
      else $error("port zero latch write not stored");

   pullup_input_a: assert property (
      ##1 (o_pullup_en == ($past(pu) & $past(dir))) and ((o_pullup_en & ~$past(dir)) == '0))
      else $error("pull-up enabled on a driving pin");

   pullup_absent_a: assert property (
      (pu & ~`MPG_PU_MASK) == '0 ##1 o_pullup_en[15:14] == 2'b00)
      else $error("pull-up present on a pin without one");

   open_drain_a: assert property (
      ##1 ((o_pin_out & `MPG_OD_MASK) == '0)
      && (o_pin_oe[15:14] == ($past(~dir[15:14]) & $past(~value[15:14]))))
      else $error("open-drain pin drove high or missed low");

   push_pull_a: assert property (
      ##1 ((o_pin_oe & ~`MPG_OD_MASK) == ($past(~dir) & ~`MPG_OD_MASK)))
      else $error("push-pull enable does not follow direction");

   alt_drive_a: assert property (
      (i_alt_en[2] && !dir[2]) |=> o_pin_out[2] == $past(i_alt_out[2]) && o_pin_oe[2])
      else $error("alternate output not driven on pin");

   read_view_a: assert property (
      (dec.kind == KIND_DATA && dec.port == PORT1 && dir[2:2] == 1'b0)
      |-> rif.rdata[0] == latch[2])
      else $error("output-mode read did not return the latch");

   read_input_a: assert property (
      (dec.kind == KIND_DATA && dec.port == PORT0 && dir[0])
      |-> rif.rdata[0] == pin_sync[0])
      else $error("input-mode read did not return the pin");

   unmapped_read_a: assert property (
      (dec.kind == KIND_NONE) |-> rif.rdata == 8'h00)
      else $error("unmapped register read not zero");

   od_drive_low_a: assert property (
      (!dir[14] && !value[14]) |=> (o_pin_oe[14] && !o_pin_out[14]))
      else $error("open-drain pin not pulled low");

   od_release_a: assert property (
      (!dir[15] && value[15]) |=> (!o_pin_oe[15] && !o_pin_out[15]))
      else $error("open-drain pin not released");

   input_no_drive_a: assert property (
      ##1 ((o_pin_oe & $past(dir)) == '0))
      else $error("input-mode pin is driven");

   pullup_bits_a: assert property (
      (pu[18:17] == 2'b00) && (pu[15:14] == 2'b00))
      else $error("pull-up stored for a pin without one");

   pullup_twelve_a: assert property (
      (rif.wr && dec.kind == KIND_PU && dec.port == PORT12)
      |=> pu[16] == $past(rif.wdata[0]))
      else $error("port twelve pull-up write not stored");

   port3_latch_a: assert property (
      (rif.wr && dec.kind == KIND_DATA && dec.port == PORT3)
      |=> latch[13:10] == $past(rif.wdata[3:0]))
      else $error("port three latch write not stored");

   port12_dir_a: assert property (
      (rif.wr && dec.kind == KIND_DIR && dec.port == PORT12)
      |=> dir[18:16] == $past(rif.wdata[2:0]))
      else $error("port twelve direction write not stored");

endmodule // mpg_gpio_top
`default_nettype wire

// file: bench/mpg_board_model.sv
// Board-side pad model facing the GPIO block pins
`default_nettype none
module mpg_board_model (
   // Clock
   input wire logic i_clk,
   // Device pad side
   input wire mpg_pkg::mpg_pins_t i_out,
   input wire mpg_pkg::mpg_pins_t i_oe,
   input wire mpg_pkg::mpg_pins_t i_pu,
   // Other drivers on the board
   input wire mpg_pkg::mpg_pins_t i_ext_drv,
   input wire mpg_pkg::mpg_pins_t i_ext_val,
   output mpg_pkg::mpg_pins_t o_pad
);
   timeunit 1ns;
   timeprecision 100ps;
   import mpg_pkg::*;
   mpg_pins_t float_q = '0;
   // Undriven, unpulled pads wander so a stale level never passes a read
   always @(posedge i_clk)
      float_q <= ~float_q;
   // Device drive wins, then board drivers, then the pull-up resistor
   assign o_pad = (i_oe & i_out) | (~i_oe & i_ext_drv & i_ext_val)
                | (~i_oe & ~i_ext_drv & (i_pu | float_q));
endmodule // mpg_board_model
`default_nettype wire

// file: bench/multi_port_gpio_block_bench.sv
// Self-checking bench for the multi-port GPIO block
`include "mpg_defs.svh"
`default_nettype none
module multi_port_gpio_block_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import mpg_pkg::*;
   // --------------------------------------------------
   // Port tables and signals
   // --------------------------------------------------
   localparam int LSB[5] = '{`MPG_P0_LSB, `MPG_P1_LSB, `MPG_P3_LSB, `MPG_P6_LSB, `MPG_P12_LSB};
   localparam int WID[5] = '{`MPG_P0_W, `MPG_P1_W, `MPG_P3_W, `MPG_P6_W, `MPG_P12_W};
   // Port six has no pull-up register, so its slot holds an unmapped index
   localparam logic [15:0] IDX[3][5] = '{
      '{`MPG_IDX_DIR0, `MPG_IDX_DIR1, `MPG_IDX_DIR3, `MPG_IDX_DIR6, `MPG_IDX_DIR12},
      '{`MPG_IDX_DATA0, `MPG_IDX_DATA1, `MPG_IDX_DATA3, `MPG_IDX_DATA6, `MPG_IDX_DATA12},
      '{`MPG_IDX_PU0, `MPG_IDX_PU1, `MPG_IDX_PU3, 16'hff36, `MPG_IDX_PULLUP_REG_PORT_TWELVE}};
   localparam mpg_pins_t OD = `MPG_OD_MASK;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   wire logic hready;
   logic [31:0] hrdata;
   logic hresp;
   logic hready_q;
   logic [31:0] rd_q;
   mpg_pins_t pad, pin_out, pin_oe, pu_en, alt_in;
   mpg_pins_t alt_en = '0;
   mpg_pins_t alt_out = '0;
   mpg_pins_t ext_drv = '1;
   mpg_pins_t ext_val = '0;
   mpg_pins_t m[3];
   int n_errors = 0;
   int checked = 0;
   logic [31:0] rd;
   int p, k;
   mpg_gpio_top i_mpg_gpio_top (.i_clk(clk), .i_resetn(resetn), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
      .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp), .i_pin_in(pad), .o_pin_out(pin_out),
      .o_pin_oe(pin_oe), .o_pullup_en(pu_en), .i_alt_en(alt_en), .i_alt_out(alt_out), .o_alt_in(alt_in));
   mpg_board_model i_mpg_board_model (.i_clk(clk), .i_out(pin_out), .i_oe(pin_oe), .i_pu(pu_en),
      .i_ext_drv(ext_drv), .i_ext_val(ext_val), .o_pad(pad));
   always #4 clk = ~clk;
   // Bus answers are taken as they stood just before each rising edge
   always @(negedge clk)
   begin
      hready_q <= hready;
      rd_q <= hrdata;
   end
   // --------------------------------------------------
   // Expectations and tasks
   // --------------------------------------------------
   function automatic mpg_pins_t f_val();
      return (alt_en & alt_out) | (~alt_en & m[1]);
   endfunction
   function automatic mpg_pins_t f_oe();
      return ~m[0] & (~OD | ~f_val());
   endfunction
   function automatic mpg_pins_t f_pad();
      return (f_oe() & f_val()) | (~f_oe() & ext_val);
   endfunction
   function automatic logic [7:0] f_reg(input int kk, input int pp);
      logic [7:0] r;
      mpg_pins_t src;
      src = (kk == 0) ? m[0] : (kk == 1) ? ((m[0] & f_pad()) | (~m[0] & m[1])) : m[2];
      r = (kk == 0) ? 8'hff : 8'h00;
      for (int b = 0; b < WID[pp]; b++)
         r[b] = src[LSB[pp] + b];
      return r;
   endfunction
   task automatic wrap_up();
      if (n_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [31:0] rv);
      int n;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {14'h0, idx, 2'b00};
      hwrite <= wr;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hready_q !== 1'b1 && n < 50);
      if (hready_q !== 1'b1)
      begin
         n_errors++;
         wrap_up();
      end
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hready_q !== 1'b1 && n < 100);
      rv = rd_q;
      if (hready_q !== 1'b1)
      begin
         n_errors++;
         wrap_up();
      end
   endtask
   task automatic wr_reg(input int kk, input int pp, input logic [7:0] wd);
      logic [31:0] dummy;
      bus(1'b1, IDX[kk][pp], wd, dummy);
      for (int b = 0; b < WID[pp]; b++)
         if (!(kk == 2 && (pp == 3 || (pp == 4 && b > 0))))
            m[kk][LSB[pp] + b] = wd[b];
   endtask
   task automatic check_pins();
      repeat (8) @(posedge clk);
      chk(32'(pin_oe), 32'(f_oe()));
      chk(32'(pin_out & f_oe() & ~OD), 32'(f_val() & f_oe() & ~OD));
      chk(32'(pu_en), 32'(m[2] & m[0]));
      chk(32'(alt_in), 32'(f_pad()));
   endtask
   task automatic rd_all();
      logic [31:0] v;
      for (int kk = 0; kk < 3; kk++)
         for (int pp = 0; pp < 5; pp++)
         begin
            bus(1'b0, IDX[kk][pp], 8'h00, v);
            chk(v, 32'(f_reg(kk, pp)));
         end
      bus(1'b0, 16'hff02, 8'h00, v);
      chk(v, 32'h0);
      chk(32'(hresp), 32'h0);
   endtask
   task automatic do_reset();
      resetn <= 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      m = '{`MPG_DIR_RST, `MPG_LATCH_RST, `MPG_PU_RST};
      @(posedge clk);
   endtask
   // --------------------------------------------------
   // Main sequence
   // --------------------------------------------------
   initial
   begin
      void'($urandom(24));
      do_reset();
      check_pins();
      rd_all();
      // Pull-ups alone hold undriven input pads high
      ext_drv <= '0;
      wr_reg(2, 1, 8'hff);
      wr_reg(2, 4, 8'hff);
      repeat (8) @(posedge clk);
      bus(1'b0, IDX[1][1], 8'h00, rd);
      chk(rd, 32'hff);
      ext_drv <= '1;
      for (int it = 0; it < 60; it++)
      begin
         ext_val <= mpg_pins_t'($urandom);
         alt_en <= mpg_pins_t'($urandom & $urandom & $urandom);
         alt_out <= mpg_pins_t'($urandom);
         p = $urandom % 5;
         k = $urandom % 3;
         wr_reg(k, p, 8'($urandom));
         if (k != 1)
         begin
            bus(1'b0, IDX[k][p], 8'h00, rd);
            chk(rd, 32'(f_reg(k, p)));
         end
         check_pins();
         rd_all();
      end
      // Ports one and six switched to output, port six latch written with 8'h02
      wr_reg(0, 1, 8'h00);
      wr_reg(0, 3, 8'h00);
      wr_reg(1, 3, 8'h02);
      check_pins();
      rd_all();
      do_reset();
      check_pins();
      rd_all();
      wrap_up();
   end
endmodule // multi_port_gpio_block_bench
`default_nettype wire
